/* File: design/port_master_process_image_mapper.sv */
// process image mapper for a four-port master with an ahb-lite register slave
//
// Design decisions made here: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none

// Operation
// - image length follows 44, 70 or 134 setting
// - byte 0 holds pin-2/pin-4 pair per port
// - pin-4 input shown only in digital input
// - even output bits drive pin 4 in output
// - byte 1 and output status bytes read zero
// - process area spans byte 2 to size-5
// - ports packed in order, leftovers read zero
// - each port holds 32 bytes each way
// - status bit 0 flags identity mismatch
// - status bit 1 flags actual size over mapping
// - status bits 2, 3 flag line shorts
// - status bit 4 flags stored parameters valid
// - bit 5 link active, bit 6 event pending
// - status bit 7 flags input data valid
// - invalid input data keeps previous image bytes
module port_master_process_image_mapper
    import image_mapper_pkg::*;
#(
    parameter logic HAS_PIN2 = 1'b1
)
(
    input wire logic clk,
    input wire logic reset,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic irq,
    input wire logic [7:0] img_rd_addr,
    output logic [7:0] img_rd_data,
    input wire logic img_wr_valid,
    input wire logic [7:0] img_wr_addr,
    input wire logic [7:0] img_wr_data,
    input wire logic [3:0] pin2_direct_input,
    input wire logic [3:0] pin4_direct_input,
    output logic [3:0] pin4_direct_output,
    input wire logic port_in_valid,
    input wire logic [1:0] port_in_port,
    input wire logic [4:0] port_in_index,
    input wire logic [7:0] port_in_data,
    input wire logic [1:0] port_out_port,
    input wire logic [4:0] port_out_index,
    output logic [7:0] port_out_data,
    input wire logic [3:0] identity_mismatch,
    input wire logic [23:0] port_actual_size,
    input wire logic [3:0] supply_line_short,
    input wire logic [3:0] switch_line_short,
    input wire logic [3:0] stored_params_valid,
    input wire logic [3:0] link_active,
    input wire logic [3:0] event_pending,
    input wire logic [3:0] input_data_valid
);

    typedef struct packed {
        logic [1:0] size_sel;
        logic [3:0][1:0] port_mode;
        logic [3:0][5:0] map_size;
        logic [PD_DEPTH-1:0][7:0] in_pd;
        logic [PD_DEPTH-1:0][7:0] out_pd;
        logic [7:0] out_byte0;
        logic [3:0] pin2_in;
        logic [3:0] pin4_in;
        logic [3:0][7:0] quality;
        logic [EVT_WIDTH-1:0] evt_status;
        logic [EVT_WIDTH-1:0] evt_enable;
        logic cfg_bad;
        logic [7:0] ahb_addr;
        logic ahb_write;
        logic ahb_read;
        logic [31:0] hrdata;
        logic hreadyout;
        logic irq;
        logic [7:0] img_rd_data;
        logic [7:0] port_out_data;
        logic [3:0] pin4_out;
        logic primed;
    } state_t;

    state_t state;
    state_t next_state;

    // image length for the size setting; unused code falls back to 44
    function automatic logic [7:0] image_length(input logic [1:0] sel);
        case (sel)
            SIZE_SEL_70: image_length = IMG_LEN_70;
            SIZE_SEL_134: image_length = IMG_LEN_134;
            default: image_length = IMG_LEN_44;
        endcase
    endfunction

    // capacity clamp of a mapping size field
    function automatic logic [5:0] clamp_size(input logic [5:0] v);
        clamp_size = (v > PORT_PD_MAX) ? PORT_PD_MAX : v;
    endfunction

    // first image byte of a port's packed area
    function automatic logic [7:0] port_offset(input state_t s, input int p);
        logic [7:0] off;
        off = PD_START;
        for (int i = 0; i < p; i++)
        begin
            off = off + {2'h0, s.map_size[i]};
        end
        port_offset = off;
    endfunction

    // locate the port and index behind an image byte of the process area
    function automatic logic [7:0] pd_slot(input state_t s, input logic [7:0] a, output logic hit);
        logic [7:0] off;
        logic [7:0] slot;
        hit = 1'b0;
        slot = 8'h00;
        for (int p = 0; p < NUM_PORTS; p++)
        begin
            off = port_offset(s, p);
            if (!hit && a >= off && a < off + {2'h0, s.map_size[p]}
                && a < image_length(s.size_sel) - STATUS_BYTES)
            begin
                hit = 1'b1;
                slot = 8'(p * 32) + (a - off);
            end
        end
        pd_slot = slot;
    endfunction

    // input image byte at address a
    // status bytes take the last four positions, ahead of any clipped port data
    function automatic logic [7:0] input_byte(input state_t s, input logic [7:0] a);
        logic [7:0] len;
        logic [7:0] slot;
        logic hit;
        logic [7:0] b;
        len = image_length(s.size_sel);
        b = 8'h00;
        slot = pd_slot(s, a, hit);
        if (a == 8'h00)
        begin
            for (int p = 0; p < NUM_PORTS; p++)
            begin
                b[2*p+1] = s.pin2_in[p] & HAS_PIN2;
                b[2*p] = s.pin4_in[p] & (s.port_mode[p] == MODE_DIG_IN);
            end
        end
        else if (a >= len - STATUS_BYTES && a < len)
        begin
            b = s.quality[2'(a - (len - STATUS_BYTES))];
        end
        else if (hit)
        begin
            b = s.in_pd[7'(slot)];
        end
        input_byte = b; // byte 1 and unmapped bytes stay zero
    endfunction

    // register read multiplexer
    // unmapped and write-only offsets read as zero
    function automatic logic [31:0] read_word(input state_t s, input logic [7:0] a);
        logic [7:0] sum;
        logic [31:0] w;
        w = 32'h0000_0000;
        sum = port_offset(s, NUM_PORTS) - PD_START;
        case (a)
            REG_CONTROL:
            begin
                w[CTRL_SIZE_LSB +: 2] = s.size_sel;
                w[CTRL_MODE_LSB +: 8] = s.port_mode;
            end
            REG_MAP_SIZE:
            begin
                for (int p = 0; p < NUM_PORTS; p++)
                begin
                    w[p*MAP_FIELD_STRIDE +: 6] = s.map_size[p];
                end
            end
            REG_QUALITY: w = s.quality;
            REG_EVT_STATUS: w[EVT_WIDTH-1:0] = s.evt_status;
            REG_EVT_ENABLE: w[EVT_WIDTH-1:0] = s.evt_enable;
            REG_INFO: w = {8'h00, sum, 7'h00, ~s.cfg_bad, image_length(s.size_sel)};
            default: w = 32'h0000_0000;
        endcase
        read_word = w;
    endfunction

    // next-state logic
    always_comb
    begin
        logic [7:0] slot;
        logic hit;
        logic [7:0] sum;
        logic [EVT_WIDTH-1:0] evt_set;
        logic [EVT_WIDTH-1:0] evt_clr;
        logic [7:0] q;
        slot = 8'h00;
        hit = 1'b0;
        sum = 8'h00;
        evt_set = '0;
        evt_clr = '0;
        q = 8'h00;
        next_state = state;

        // pins sampled every cycle
        next_state.pin2_in = pin2_direct_input;
        next_state.pin4_in = pin4_direct_input;

        // change events armed only from the second cycle after reset,
        // so the first refresh of the quality bytes raises no false event
        next_state.primed = 1'b1;

        // quality bytes rebuilt from present conditions
        for (int p = 0; p < NUM_PORTS; p++)
        begin
            q[Q_IDENTITY_MISMATCH] = identity_mismatch[p];
            q[Q_MAP_EXCEEDED] = port_actual_size[p*6 +: 6] > state.map_size[p];
            q[Q_SUPPLY_SHORT] = supply_line_short[p];
            q[Q_SWITCH_SHORT] = switch_line_short[p];
            q[Q_STORED_VALID] = stored_params_valid[p];
            q[Q_LINK_ACTIVE] = link_active[p];
            q[Q_EVENT] = event_pending[p];
            q[Q_DATA_VALID] = input_data_valid[p];
            next_state.quality[p] = q;
            evt_set[p] = state.primed && (q != state.quality[p]);
        end

        // configuration check against the chosen size
        sum = port_offset(state, NUM_PORTS) - PD_START;
        // an exact fit is legal: 134 bytes carry four full 32-byte ports
        next_state.cfg_bad = (image_length(state.size_sel) < sum + CFG_OVERHEAD);
        evt_set[EVT_CFG_BAD] = next_state.cfg_bad & ~state.cfg_bad;

        // port input data lands only while the port's data is valid
        if (port_in_valid && input_data_valid[port_in_port])
        begin
            next_state.in_pd[{port_in_port, port_in_index}] = port_in_data;
        end

        // fieldbus output image writes
        slot = pd_slot(state, img_wr_addr, hit);
        if (img_wr_valid)
        begin
            if (img_wr_addr == 8'h00)
            begin
                next_state.out_byte0 = img_wr_data;
            end
            else if (hit)
            begin
                next_state.out_pd[7'(slot)] = img_wr_data;
            end
        end

        // pin-4 outputs from even bits in output mode
        for (int p = 0; p < NUM_PORTS; p++)
        begin
            next_state.pin4_out[p] = state.out_byte0[2*p] & (state.port_mode[p] == MODE_DIG_OUT);
        end

        // image and port side read ports
        next_state.img_rd_data = input_byte(state, img_rd_addr);
        next_state.port_out_data = state.out_pd[{port_out_port, port_out_index}];

        // ahb-lite data phase: writes take effect, reads answer after one wait
        // hsize is not decoded: every register is one whole word
        if (state.ahb_write)
        begin
            case (state.ahb_addr)
                REG_CONTROL:
                begin
                    next_state.size_sel = hwdata[CTRL_SIZE_LSB +: 2];
                    next_state.port_mode = hwdata[CTRL_MODE_LSB +: 8];
                end
                REG_MAP_SIZE:
                begin
                    for (int p = 0; p < NUM_PORTS; p++)
                    begin
                        next_state.map_size[p] = clamp_size(hwdata[p*MAP_FIELD_STRIDE +: 6]);
                    end
                end
                REG_EVT_ENABLE: next_state.evt_enable = hwdata[EVT_WIDTH-1:0];
                REG_EVT_CLEAR: evt_clr = hwdata[EVT_WIDTH-1:0];
                default: ;
            endcase
        end
        next_state.ahb_write = 1'b0;
        next_state.hreadyout = 1'b1;
        if (state.ahb_read)
        begin
            next_state.hrdata = read_word(state, state.ahb_addr);
            next_state.ahb_read = 1'b0;
        end
        else if (hsel && hready && htrans == AHB_NONSEQ && state.hreadyout)
        begin
            next_state.ahb_addr = {haddr[7:2], 2'h0};
            next_state.ahb_write = hwrite;
            next_state.ahb_read = ~hwrite;
            next_state.hreadyout = hwrite;
        end

        // sticky events: set wins over clear
        next_state.evt_status = (state.evt_status & ~evt_clr) | evt_set;
        next_state.irq = |(next_state.evt_status & state.evt_enable);
    end

    // state register
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state <= '0;
            state.map_size <= {4{MAP_SIZE_RESET}};
            state.hreadyout <= 1'b1;
        end
        else
        begin
            state <= next_state;
        end
    end

    // outputs straight from flops, except hresp, which is tied low
    assign hrdata = state.hrdata;
    assign hreadyout = state.hreadyout;
    assign hresp = 1'b0; // always okay
    assign irq = state.irq;
    assign img_rd_data = state.img_rd_data;
    assign pin4_direct_output = state.pin4_out;
    assign port_out_data = state.port_out_data;

endmodule

`default_nettype wire

/* File: design/image_mapper_pkg.sv */
// shared constants for the process image mapper
package image_mapper_pkg;
    // master size settings and image lengths
    localparam logic [1:0] SIZE_SEL_44 = 2'h0;
    localparam logic [1:0] SIZE_SEL_70 = 2'h1;
    localparam logic [1:0] SIZE_SEL_134 = 2'h2;
    localparam logic [7:0] IMG_LEN_44 = 8'h2C;
    localparam logic [7:0] IMG_LEN_70 = 8'h46;
    localparam logic [7:0] IMG_LEN_134 = 8'h86;
    localparam int NUM_PORTS = 4;
    localparam logic [7:0] PD_START = 8'h02;
    localparam logic [7:0] STATUS_BYTES = 8'h04;
    localparam logic [7:0] CFG_OVERHEAD = 8'h06;
    localparam logic [5:0] PORT_PD_MAX = 6'h20;
    localparam int PD_DEPTH = 128;
    // port operating modes
    localparam logic [1:0] MODE_LINK = 2'h0;
    localparam logic [1:0] MODE_DIG_IN = 2'h1;
    localparam logic [1:0] MODE_DIG_OUT = 2'h2;
    // register byte addresses
    localparam logic [7:0] REG_CONTROL = 8'h00;
    localparam logic [7:0] REG_MAP_SIZE = 8'h04;
    localparam logic [7:0] REG_QUALITY = 8'h08;
    localparam logic [7:0] REG_EVT_STATUS = 8'h0C;
    localparam logic [7:0] REG_EVT_ENABLE = 8'h10;
    localparam logic [7:0] REG_EVT_CLEAR = 8'h14;
    localparam logic [7:0] REG_INFO = 8'h18;
    // control field positions
    localparam int CTRL_SIZE_LSB = 0;
    localparam int CTRL_MODE_LSB = 8;
    localparam int MAP_FIELD_STRIDE = 8;
    // event bits
    localparam int EVT_WIDTH = 5;
    localparam int EVT_CFG_BAD = 4;
    // status bit positions inside a port quality byte
    localparam int Q_IDENTITY_MISMATCH = 0;
    localparam int Q_MAP_EXCEEDED = 1;
    localparam int Q_SUPPLY_SHORT = 2;
    localparam int Q_SWITCH_SHORT = 3;
    localparam int Q_STORED_VALID = 4;
    localparam int Q_LINK_ACTIVE = 5;
    localparam int Q_EVENT = 6;
    localparam int Q_DATA_VALID = 7;
    // reset values and the ahb nonseq transfer code
    localparam logic [5:0] MAP_SIZE_RESET = 6'h02;
    localparam logic [1:0] AHB_NONSEQ = 2'h2;
endpackage

/* File: dv/image_mapper_chk.sv */
// port checker for the process image mapper
`timescale 1ns/1ns
`default_nettype none
module image_mapper_chk
(
    input wire logic clk,
    input wire logic reset,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic irq,
    input wire logic [7:0] img_rd_addr,
    input wire logic [7:0] img_rd_data,
    input wire logic [3:0] pin2_direct_input,
    input wire logic [3:0] pin4_direct_output
);
    logic [1:0] calm;
    logic [3:0] last_pins;
    wire logic take = hsel && hready && htrans == 2'h2 && hreadyout;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // cycles the pin-2 inputs have stayed put
    always_ff @(posedge clk)
    begin
        last_pins <= pin2_direct_input;
        calm <= (reset || pin2_direct_input != last_pins) ? 2'h0 : (calm == 2'h3 ? 2'h3 : calm + 2'h1);
    end
    a_hresp_okay: assert property (hresp == 1'b0) else $error("hresp not okay");
    a_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout) else $error("read wait wrong");
    a_write_fast: assert property (take && hwrite |=> hreadyout) else $error("write stalled");
    a_wait_cause: assert property (!hreadyout |-> $past(take && !hwrite)) else $error("wait without read");
    a_reset_quiet: assert property ($fell(reset) |-> pin4_direct_output == 4'h0 && !irq) else $error("outputs after reset");
    a_pin2_pairs: assert property (calm == 2'h3 && img_rd_addr == 8'h00 |=>
        {img_rd_data[7], img_rd_data[5], img_rd_data[3], img_rd_data[1]} == $past(pin2_direct_input))
        else $error("pin-2 bits wrong");
    a_byte1_zero: assert property (img_rd_addr == 8'h01 |=> img_rd_data == 8'h00) else $error("byte 1 not zero");
    a_past_len: assert property (img_rd_addr >= 8'h86 |=> img_rd_data == 8'h00) else $error("beyond image not zero");
    c_read: cover property (take && !hwrite);
    c_irq: cover property (irq);
    c_pin4: cover property (pin4_direct_output != 4'h0);
endmodule
bind port_master_process_image_mapper image_mapper_chk u_chk (.clk, .reset, .hsel, .htrans, .hwrite, .hready,
    .hreadyout, .hresp, .irq, .img_rd_addr, .img_rd_data, .pin2_direct_input, .pin4_direct_output);
`default_nettype wire

/* File: dv/fieldbus_model.sv */
// fieldbus controller side: reads the input image, writes the output image
`timescale 1ns/1ns
`default_nettype none
module fieldbus_model
(
    input wire logic clk,
    output logic [7:0] img_rd_addr = 8'h00,
    input wire logic [7:0] img_rd_data,
    output logic img_wr_valid = 1'b0,
    output logic [7:0] img_wr_addr = 8'h00,
    output logic [7:0] img_wr_data = 8'h00
);
    // one image byte, answer one cycle after the address
    task rd(input logic [7:0] a, output logic [7:0] b);
        @(posedge clk);
        img_rd_addr <= a;
        @(posedge clk);
        #1 b = img_rd_data;
    endtask
    // one output byte pulse, data scrambled once released
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        img_wr_valid <= 1'b1;
        img_wr_addr <= a;
        img_wr_data <= d;
        @(posedge clk);
        img_wr_valid <= 1'b0;
        img_wr_data <= ~d;
    endtask
endmodule
`default_nettype wire

/* File: dv/tb.sv */
// self-checking bench for the process image mapper
`timescale 1ns/1ns
`default_nettype none
module tb;
    import image_mapper_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, r;
    logic hreadyout, hresp, irq, img_wr_valid;
    logic [7:0] img_rd_addr, img_rd_data, img_wr_addr, img_wr_data, port_out_data, b;
    logic [3:0] pin2_direct_input = 4'hA, pin4_direct_input = 4'hF, pin4_direct_output;
    logic port_in_valid = 1'b0;
    logic [1:0] port_in_port = 2'h0, port_out_port = 2'h0;
    logic [4:0] port_in_index = 5'h0, port_out_index = 5'h0;
    logic [7:0] port_in_data = 8'h00;
    logic [3:0] identity_mismatch = 4'h1, supply_line_short = 4'h2, switch_line_short = 4'h4;
    logic [3:0] stored_params_valid = 4'h8, link_active = 4'h3, event_pending = 4'h5, input_data_valid = 4'hF;
    logic [23:0] port_actual_size = 24'h082083;
    int num_errors = 0;
    int n_tests = 0;
    always #50 clk = ~clk;
    port_master_process_image_mapper dut (.clk, .reset, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .irq, .img_rd_addr, .img_rd_data, .img_wr_valid,
        .img_wr_addr, .img_wr_data, .pin2_direct_input, .pin4_direct_input, .pin4_direct_output, .port_in_valid,
        .port_in_port, .port_in_index, .port_in_data, .port_out_port, .port_out_index, .port_out_data,
        .identity_mismatch, .port_actual_size, .supply_line_short, .switch_line_short, .stored_params_valid,
        .link_active, .event_pending, .input_data_valid);
    fieldbus_model fb (.clk, .img_rd_addr, .img_rd_data, .img_wr_valid, .img_wr_addr, .img_wr_data);
    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e)
        begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    // one single-word transfer, read data left in r
    task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= AHB_NONSEQ;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task load(input int p, input int i, input logic [7:0] d);
        @(posedge clk);
        port_in_valid <= 1'b1;
        port_in_port <= 2'(p);
        port_in_index <= 5'(i);
        port_in_data <= d;
        @(posedge clk);
        port_in_valid <= 1'b0;
    endtask
    // expected status byte with all mapping sizes at two
    function automatic logic [7:0] q(input int p);
        q = {input_data_valid[p], event_pending[p], link_active[p], stored_params_valid[p],
            switch_line_short[p], supply_line_short[p], port_actual_size[6*p+:6] > 6'h02, identity_mismatch[p]};
    endfunction
    function automatic logic [7:0] eb(input int k, input int len);
        eb = 8'h00;
        if (k >= len - 4)
            eb = q(k - len + 4);
        else if (k >= 2 && k < 10)
            eb = 8'(16 * ((k - 2) / 2) + k % 2 + 1);
    endfunction
    task conclude;
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (5000) @(posedge clk);
        num_errors++;
        conclude;
    end
    initial
    begin
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        ahb(1'b0, REG_MAP_SIZE, 32'h0);
        chk("map", r, 32'h02020202);
        ahb(1'b0, REG_INFO, 32'h0);
        chk("info44", r, 32'h0008012C);
        ahb(1'b0, 8'h1C, 32'h0);
        chk("unmapped", r, 32'h0);
        $display("test registers done");
        for (int p = 0; p < 4; p++)
            for (int i = 0; i < 2; i++)
                load(p, i, 8'(16 * p + i + 1));
        for (int k = 1; k < 44; k++)
        begin
            fb.rd(8'(k), b);
            chk("image44", b, eb(k, 44));
        end
        $display("test packing done");
        fb.rd(8'h00, b);
        chk("pins link", b, 8'h88);
        ahb(1'b1, REG_CONTROL, 32'h00000900);
        fb.rd(8'h00, b);
        chk("pins in", b, 8'h89);
        fb.wr(8'h00, 8'hFF);
        fb.wr(8'h02, 8'hA5);
        repeat (3) @(posedge clk);
        chk("pin4 out", pin4_direct_output, 4'h2);
        chk("out data", port_out_data, 8'hA5);
        $display("test pins done");
        input_data_valid <= 4'hE;
        load(0, 0, 8'h77);
        repeat (3) @(posedge clk);
        fb.rd(8'h02, b);
        chk("held", b, 8'h01);
        ahb(1'b1, REG_CONTROL, 32'h1);
        ahb(1'b0, REG_INFO, 32'h0);
        chk("info70", r, 32'h00080146);
        fb.rd(8'd66, b);
        chk("status70", b, q(0));
        fb.rd(8'd69, b);
        chk("status70", b, q(3));
        ahb(1'b1, REG_CONTROL, 32'h2);
        ahb(1'b0, REG_INFO, 32'h0);
        chk("info134", r, 32'h00080186);
        identity_mismatch <= 4'hE;
        stored_params_valid <= 4'h7;
        ahb(1'b0, REG_QUALITY, 32'h0);
        chk("quality", r, {q(3), q(2), q(1), q(0)});
        fb.rd(8'd133, b);
        chk("status134", b, q(3));
        fb.rd(8'h90, b);
        chk("beyond", b, 8'h00);
        $display("test sizes done");
        ahb(1'b1, REG_EVT_CLEAR, 32'h1F);
        ahb(1'b1, REG_EVT_ENABLE, 32'h10);
        ahb(1'b1, REG_MAP_SIZE, 32'h3F3F3F3F);
        ahb(1'b0, REG_MAP_SIZE, 32'h0);
        chk("clamp", r, 32'h20202020);
        ahb(1'b0, REG_INFO, 32'h0);
        chk("fit134", r, 32'h00800186);
        ahb(1'b1, REG_CONTROL, 32'h0);
        ahb(1'b0, REG_INFO, 32'h0);
        chk("invalid", r, 32'h0080002C);
        chk("irq on", irq, 1'b1);
        ahb(1'b0, REG_EVT_STATUS, 32'h0);
        chk("events", r, 32'h11);
        ahb(1'b1, REG_EVT_ENABLE, 32'h0);
        repeat (2) @(posedge clk);
        chk("irq masked", irq, 1'b0);
        ahb(1'b1, REG_EVT_ENABLE, 32'h10);
        ahb(1'b1, REG_EVT_CLEAR, 32'h10);
        repeat (2) @(posedge clk);
        chk("irq cleared", irq, 1'b0);
        ahb(1'b0, REG_EVT_STATUS, 32'h0);
        chk("left", r, 32'h01);
        $display("test events done");
        conclude;
    end
endmodule
`default_nettype wire
